// file: core/acs_cnt.sv
`timescale 1ns/1ps
module acs_cnt #(
    parameter int W = 8
) (
    input wire logic i_clk, // Converter clock
    input wire logic i_rst_n, // Sync reset, active low
    input wire logic i_load, // Load start value
    input wire logic [W-1:0] i_val, // Start value
    input wire logic i_step, // Count one step down
    output logic o_zero // Count has run out
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } acs_cnt_t;

    acs_cnt_t s_q;
    acs_cnt_t s_d;

    always_comb begin
        s_d = s_q;
        if (i_load) begin
            s_d.cnt = i_val;
        end else if (i_step && s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_zero = (s_q.cnt == '0);
endmodule : acs_cnt

// file: core/acs_pkg.sv
package acs_pkg;
    // ******************************
    // Register map
    // ******************************
    localparam logic [31:0] ADDR_CTRL = 32'h5000_1900;
    localparam logic [31:0] ADDR_TIM = 32'h5000_1902;
    localparam logic [31:0] ADDR_IVL = 32'h5000_1904;
    localparam logic [31:0] ADDR_OFFP = 32'h5000_1906;
    localparam logic [31:0] ADDR_OFFN = 32'h5000_1908;
    localparam logic [31:0] ADDR_CLR = 32'h5000_190A;
    localparam logic [31:0] ADDR_RES = 32'h5000_190C;

    // ******************************
    // Field positions
    // ******************************
    localparam int B_EN = 0;
    localparam int B_GO = 1;
    localparam int B_REP = 2;
    localparam int B_CLKSEL = 3;
    localparam int B_DONE = 4;
    localparam int B_MINT = 5;
    localparam int B_SE = 6;
    localparam int B_SIGN = 13;
    localparam int B_CHOP = 14;
    localparam int SEL_LO = 8;
    localparam int SEL_HI = 12;
    localparam int B_ATTN = 0;
    localparam int B_DMA = 3;
    localparam int B_RSVD = 4;
    localparam int AVG_LO = 5;
    localparam int AVG_HI = 7;
    localparam int WIN_LO = 8;
    localparam int WIN_HI = 11;
    localparam int CAP_LO = 12;
    localparam int CAP_HI = 15;
    localparam int DEL_LO = 0;
    localparam int DEL_HI = 7;
    localparam int IVL_LO = 8;
    localparam int IVL_HI = 15;

    // ******************************
    // Reset values and constants
    // ******************************
    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [15:0] RST_TIM = 16'h0000;
    localparam logic [15:0] RST_IVL = 16'h0040;
    localparam logic [9:0] RST_OFF = 10'h200;
    localparam logic [15:0] RST_RES = 16'h0000;
    localparam logic [4:0] SEL_ATTN_A = 5'h07;
    localparam logic [4:0] SEL_ATTN_B = 5'h08;
    localparam int SMPL_UNIT = 32;
    localparam int PWR_UNIT = 32;
    localparam int DATA_W = 10;
    localparam int ACC_W = 17;
    localparam int EXTRA_BITS = 6;
    localparam logic [2:0] AVG_MAX = 3'h7;
    localparam real TICK_MS = 1.024;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SAMPLE = 3'b001,
        ST_CONV = 3'b010,
        ST_CAPT = 3'b011,
        ST_GAP = 3'b100
    } acs_st_t;
endpackage : acs_pkg

// file: core/acs_seq.sv
`timescale 1ns/1ps
module acs_seq (
    input wire logic i_clk, // Converter clock
    input wire logic i_rst_n, // Sync reset, active low
    input wire logic [31:0] i_addr, // Register address
    input wire logic [15:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [15:0] o_rdata, // Read data, cycle after
    input wire logic i_conv_done, // Core handshake, async
    input wire logic [9:0] i_conv_data, // Core sample value
    input wire logic i_tick, // 1.024ms reference, async
    output logic o_ldo_en, // Reference regulator on
    output logic o_adc_en, // Converter core enabled
    output logic o_clk_sel, // 0 internal, 1 digital
    output logic o_sample, // Sampling switch closed
    output logic o_start, // Start trigger pulse
    output logic o_sign, // Polarity swap to core
    output logic o_se, // Single-ended inputs
    output logic [4:0] o_sel, // Input select code
    output logic o_attn, // Input attenuator on
    output logic [9:0] o_offp, // Positive trim value
    output logic o_offp_en, // Positive trim applied
    output logic [9:0] o_offn, // Negative trim value
    output logic o_offn_en, // Negative trim applied
    output logic o_irq // Done request to controller
);
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] tim;
        logic [15:0] ivl;
        logic [9:0] offp;
        logic [9:0] offn;
        logic done;
        logic [15:0] result;
        logic [15:0] rdata;
        acs_pkg::acs_st_t st;
        logic [7:0] left;
        logic [acs_pkg::ACC_W-1:0] acc;
        logic sgn;
        logic pend;
        logic adc_on;
        logic [1:0] dsync;
        logic dprev;
        logic [1:0] tsync;
        logic tprev;
        logic start;
        logic sample;
        logic attn;
        logic offp_en;
        logic offn_en;
        logic irq;
    } acs_state_t;

    acs_state_t s_q;
    acs_state_t s_d;

    logic pwr_load;
    logic pwr_zero;
    logic [12:0] pwr_val;
    logic smp_load;
    logic smp_zero;
    logic [8:0] smp_val;
    logic gap_load;
    logic gap_zero;
    logic gap_step;

    // ******************************
    // Timers
    // ******************************
    acs_cnt #(.W(13)) u_pwr (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_load(pwr_load),
        .i_val(pwr_val),
        .i_step(1'b1),
        .o_zero(pwr_zero)
    );

    acs_cnt #(.W(9)) u_smp (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_load(smp_load),
        .i_val(smp_val),
        .i_step(1'b1),
        .o_zero(smp_zero)
    );

    acs_cnt #(.W(8)) u_gap (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_load(gap_load),
        .i_val(s_q.ivl[acs_pkg::IVL_HI:acs_pkg::IVL_LO]),
        .i_step(gap_step),
        .o_zero(gap_zero)
    );

    // ******************************
    // Next state
    // ******************************
    always_comb begin
        logic en;
        logic chop;
        logic [2:0] avg;
        logic [2:0] lg;
        logic [3:0] win;
        logic [3:0] cap;
        logic [8:0] win_len;
        logic [7:0] nsmp;
        logic [acs_pkg::ACC_W-1:0] sum;
        logic store;
        logic begin_conv;
        logic [4:0] sel;
        s_d = s_q;
        en = s_q.ctrl[acs_pkg::B_EN];
        chop = s_q.ctrl[acs_pkg::B_CHOP];
        avg = s_q.tim[acs_pkg::AVG_HI:acs_pkg::AVG_LO];
        win = s_q.tim[acs_pkg::WIN_HI:acs_pkg::WIN_LO];
        cap = s_q.tim[acs_pkg::CAP_HI:acs_pkg::CAP_LO];
        sel = s_q.ctrl[acs_pkg::SEL_HI:acs_pkg::SEL_LO];
        pwr_load = 1'b0;
        smp_load = 1'b0;
        gap_load = 1'b0;
        store = 1'b0;
        begin_conv = 1'b0;
        smp_val = '0;
        win_len = (win == 4'h0) ? 9'h000
            : 9'(int'(win) * acs_pkg::SMPL_UNIT - 1);
        lg = (chop && avg == 3'h0) ? 3'h1 : avg;
        nsmp = 8'(1 << lg);
        pwr_val = 13'(int'(s_q.ivl[acs_pkg::DEL_HI:acs_pkg::DEL_LO])
            * acs_pkg::PWR_UNIT);
        sum = s_q.acc + acs_pkg::ACC_W'(i_conv_data);

        // Synchronisers for core handshake and tick
        s_d.dsync = {s_q.dsync[0], i_conv_done};
        s_d.dprev = s_q.dsync[1];
        s_d.tsync = {s_q.tsync[0], i_tick};
        s_d.tprev = s_q.tsync[1];
        gap_step = s_q.tsync[1] && !s_q.tprev;
        s_d.start = 1'b0;

        // Register writes
        if (i_wr) begin
            case (i_addr)
                acs_pkg::ADDR_CTRL: begin
                    s_d.ctrl = i_wdata;
                end
                acs_pkg::ADDR_TIM: begin
                    s_d.tim = i_wdata;
                    s_d.tim[acs_pkg::B_RSVD] = 1'b0;
                end
                acs_pkg::ADDR_IVL: begin
                    s_d.ivl = i_wdata;
                end
                acs_pkg::ADDR_OFFP: begin
                    s_d.offp = i_wdata[9:0];
                end
                acs_pkg::ADDR_OFFN: begin
                    s_d.offn = i_wdata[9:0];
                end
                acs_pkg::ADDR_CLR: begin
                    s_d.done = 1'b0;
                end
                default: begin
                end
            endcase
        end

        en = s_d.ctrl[acs_pkg::B_EN];
        if (!en) begin
            s_d.adc_on = 1'b0;
            s_d.pend = 1'b0;
        end else if (!s_q.adc_on && !s_q.pend) begin
            pwr_load = 1'b1;
            s_d.pend = 1'b1;
        end else if (s_q.pend && pwr_zero) begin
            s_d.pend = 1'b0;
            s_d.adc_on = 1'b1;
        end

        case (s_q.st)
            acs_pkg::ST_IDLE: begin
                begin_conv = s_q.ctrl[acs_pkg::B_GO] && s_q.adc_on;
            end
            acs_pkg::ST_SAMPLE: begin
                if (smp_zero) begin
                    s_d.sample = 1'b0;
                    s_d.start = 1'b1;
                    smp_load = (cap != 4'h0);
                    smp_val = 9'(cap);
                    s_d.st = acs_pkg::ST_CONV;
                end
            end
            acs_pkg::ST_CONV: begin
                s_d.st = acs_pkg::ST_CAPT;
            end
            acs_pkg::ST_CAPT: begin
                store = (cap == 4'h0) ? (s_q.dsync[1] && !s_q.dprev)
                    : smp_zero;
                if (store) begin
                    s_d.acc = sum;
                    s_d.left = s_q.left - 8'h01;
                    if (chop) begin
                        s_d.sgn = !s_q.sgn;
                    end
                    if (s_q.left == 8'h01) begin
                        if (lg == acs_pkg::AVG_MAX) begin
                            s_d.result = sum[16:1];
                        end else begin
                            s_d.result = 16'(sum << (acs_pkg::EXTRA_BITS
                                - int'(lg)));
                        end
                        s_d.done = 1'b1;
                        if (s_q.ctrl[acs_pkg::B_REP]) begin
                            gap_load = 1'b1;
                            s_d.st = acs_pkg::ST_GAP;
                        end else begin
                            s_d.ctrl[acs_pkg::B_GO] = 1'b0;
                            s_d.st = acs_pkg::ST_IDLE;
                        end
                    end else begin
                        smp_load = 1'b1;
                        smp_val = win_len;
                        s_d.sample = 1'b1;
                        s_d.st = acs_pkg::ST_SAMPLE;
                    end
                end
            end
            acs_pkg::ST_GAP: begin
                if (!s_q.ctrl[acs_pkg::B_REP]) begin
                    s_d.ctrl[acs_pkg::B_GO] = 1'b0;
                    s_d.st = acs_pkg::ST_IDLE;
                end else if (gap_zero) begin
                    begin_conv = 1'b1;
                end
            end
            default: begin
                s_d.st = acs_pkg::ST_IDLE;
            end
        endcase

        if (begin_conv) begin
            smp_load = 1'b1;
            smp_val = win_len;
            s_d.left = nsmp;
            s_d.acc = '0;
            s_d.sgn = s_q.ctrl[acs_pkg::B_SIGN];
            s_d.sample = 1'b1;
            s_d.st = acs_pkg::ST_SAMPLE;
        end

        // Disable aborts any conversion
        if (!en) begin
            s_d.st = acs_pkg::ST_IDLE;
            s_d.sample = 1'b0;
            s_d.start = 1'b0;
            s_d.ctrl[acs_pkg::B_GO] = 1'b0;
        end

        s_d.attn = s_d.tim[acs_pkg::B_ATTN]
            || sel == acs_pkg::SEL_ATTN_A
            || sel == acs_pkg::SEL_ATTN_B;
        s_d.offp_en = !s_q.ctrl[acs_pkg::B_SE] || !s_d.sgn;
        s_d.offn_en = !s_q.ctrl[acs_pkg::B_SE] || s_d.sgn;
        if (s_d.st == acs_pkg::ST_IDLE) begin
            s_d.sgn = s_d.ctrl[acs_pkg::B_SIGN];
        end
        s_d.irq = s_d.done && s_d.ctrl[acs_pkg::B_MINT];

        // Register reads, answer one cycle later
        s_d.rdata = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                acs_pkg::ADDR_CTRL: begin
                    s_d.rdata = s_q.ctrl;
                    s_d.rdata[acs_pkg::B_DONE] = s_q.done;
                end
                acs_pkg::ADDR_TIM: begin
                    s_d.rdata = s_q.tim;
                    s_d.rdata[acs_pkg::B_ATTN] = s_q.attn;
                end
                acs_pkg::ADDR_IVL: begin
                    s_d.rdata = s_q.ivl;
                end
                acs_pkg::ADDR_OFFP: begin
                    s_d.rdata = {6'h00, s_q.offp};
                end
                acs_pkg::ADDR_OFFN: begin
                    s_d.rdata = {6'h00, s_q.offn};
                end
                acs_pkg::ADDR_RES: begin
                    s_d.rdata = s_q.result;
                end
                default: begin
                    s_d.rdata = 16'h0000;
                end
            endcase
        end
    end

    // ******************************
    // State register
    // ******************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
            s_q.ctrl <= acs_pkg::RST_CTRL;
            s_q.tim <= acs_pkg::RST_TIM;
            s_q.ivl <= acs_pkg::RST_IVL;
            s_q.offp <= acs_pkg::RST_OFF;
            s_q.offn <= acs_pkg::RST_OFF;
            s_q.result <= acs_pkg::RST_RES;
            s_q.st <= acs_pkg::ST_IDLE;
            s_q.offp_en <= 1'b1;
            s_q.offn_en <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ******************************
    // Outputs
    // ******************************
    assign o_rdata = s_q.rdata;
    assign o_ldo_en = s_q.ctrl[acs_pkg::B_EN];
    assign o_adc_en = s_q.adc_on;
    assign o_clk_sel = s_q.ctrl[acs_pkg::B_CLKSEL];
    assign o_sample = s_q.sample;
    assign o_start = s_q.start;
    assign o_sign = s_q.sgn;
    assign o_se = s_q.ctrl[acs_pkg::B_SE];
    assign o_sel = s_q.ctrl[acs_pkg::SEL_HI:acs_pkg::SEL_LO];
    assign o_attn = s_q.attn;
    assign o_offp = s_q.offp;
    assign o_offp_en = s_q.offp_en;
    assign o_offn = s_q.offn;
    assign o_offn_en = s_q.offn_en;
    assign o_irq = s_q.irq;
endmodule : acs_seq

// file: test/acs_core_model.sv
`timescale 1ns/1ps
// ****************************************
// Converter core stand-in
// ****************************************
module acs_core_model #(
    parameter int DLY = 12,
    parameter logic [9:0] VAL = 10'h2D5
) (
    input wire logic i_clk, // Converter clock
    input wire logic i_start, // Start trigger pulse
    output logic o_done, // Sample ready handshake
    output logic [9:0] o_data // Sample value
);
    int cnt = 0;

    initial begin
        o_done = 1'b0;
        o_data = ~VAL;
    end

    // Value valid only around its handshake, inverse otherwise
    always @(posedge i_clk) begin
        if (i_start) begin
            cnt <= DLY + 8;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
        o_data <= (cnt >= 1 && cnt <= DLY + 5) ? VAL : ~VAL;
        o_done <= (cnt >= 5 && cnt <= 8);
    end
endmodule : acs_core_model

// file: test/acs_seq_asserts.sv
`timescale 1ns/1ps
// ****************************************
// Port checks
// ****************************************
module acs_seq_chk (
    input wire logic i_clk, // Converter clock
    input wire logic i_rst_n, // Sync reset, active low
    input wire logic [31:0] i_addr, // Register address
    input wire logic [15:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    input wire logic [15:0] o_rdata, // Read data
    input wire logic o_ldo_en, // Regulator on
    input wire logic o_adc_en, // Converter on
    input wire logic o_clk_sel, // Clock select
    input wire logic o_sample, // Sampling switch
    input wire logic o_start, // Start pulse
    input wire logic o_sign, // Polarity swap
    input wire logic o_se, // Single-ended inputs
    input wire logic [4:0] o_sel, // Input select
    input wire logic o_attn, // Attenuator on
    input wire logic o_offp_en, // Positive trim on
    input wire logic o_offn_en // Negative trim on
);
    logic wr_ctl;
    assign wr_ctl = i_wr && i_addr == acs_pkg::ADDR_CTRL;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_clear_reads_zero: assert property (
        i_rd && i_addr == acs_pkg::ADDR_CLR |=> o_rdata == 16'h0000)
        else $error("clear register read not zero");
    a_clksel_follow: assert property (
        wr_ctl |=> o_clk_sel == $past(i_wdata[3]))
        else $error("clock select not written");
    a_se_follow: assert property (
        wr_ctl |=> o_se == $past(i_wdata[6]))
        else $error("single-ended select not written");
    a_regulator_first: assert property (
        $rose(o_adc_en) |-> $past(o_ldo_en, 8))
        else $error("converter on before regulator settled");
    a_both_off: assert property (
        !o_ldo_en |-> !o_adc_en)
        else $error("converter on without regulator");
    a_sample_enabled: assert property (
        o_sample |-> o_adc_en)
        else $error("sampling while converter off");
    a_start_sampled: assert property (
        o_start |-> $past(o_sample))
        else $error("start without sample window");
    a_attn_forced: assert property (
        $stable(o_sel) && (o_sel == acs_pkg::SEL_ATTN_A ||
        o_sel == acs_pkg::SEL_ATTN_B) |-> o_attn)
        else $error("attenuator not forced");
    a_trim_single: assert property (
        o_se && $stable(o_se) && $stable(o_sign)
        |-> o_offp_en == !o_sign && o_offn_en == o_sign)
        else $error("single-ended trim selection wrong");
    a_trim_diff: assert property (
        !o_se && $stable(o_se) |-> o_offp_en && o_offn_en)
        else $error("differential trim not applied");
endmodule : acs_seq_chk

bind acs_seq acs_seq_chk u_chk (.*);

// file: test/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    mismatches++; $display("unexpected %s exp %0h got %0h", nm, e, g); \
    end end
// ****************************************
// Sequencer bench
// ****************************************
module testbench;
    localparam logic [9:0] VAL = 10'h2D5;
    logic i_clk;
    logic i_rst_n;
    logic [31:0] i_addr;
    logic [15:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [15:0] o_rdata;
    logic i_conv_done;
    logic [9:0] i_conv_data;
    logic i_tick;
    logic o_ldo_en;
    logic o_adc_en;
    logic o_clk_sel;
    logic o_sample;
    logic o_start;
    logic o_sign;
    logic o_se;
    logic [4:0] o_sel;
    logic o_attn;
    logic [9:0] o_offp;
    logic o_offp_en;
    logic [9:0] o_offn;
    logic o_offn_en;
    logic o_irq;
    int mismatches = 0;
    int n_compared = 0;
    int n_start = 0;
    int smp_cnt = 0;
    int smp_w = 0;
    int j;
    logic [1:0] sg;
    logic [15:0] rv;

    acs_seq dut (.*);
    acs_core_model #(.DLY(12), .VAL(VAL)) core (.i_clk(i_clk),
        .i_start(o_start), .o_done(i_conv_done), .o_data(i_conv_data));

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        if (o_start) begin
            n_start++;
            sg <= {sg[0], o_sign};
        end
        if (o_sample) begin
            smp_cnt++;
        end else if (smp_cnt != 0) begin
            smp_w = smp_cnt;
            smp_cnt = 0;
        end
    end

    task give_verdict;
        if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    task wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task rd(input logic [31:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        rv = o_rdata;
    endtask : rd

    task rc(input string nm, input logic [31:0] a, input logic [15:0] e);
        rd(a);
        `CHK(nm, e, rv)
    endtask : rc

    task wait_go;
        int k;
        for (k = 0; k < 3000; k++) begin
            rd(acs_pkg::ADDR_CTRL);
            if (rv[1] === 1'b0) return;
        end
        mismatches++;
        give_verdict();
    endtask : wait_go

    task tick;
        i_tick <= 1'b1;
        repeat (10) @(posedge i_clk);
        i_tick <= 1'b0;
        repeat (10) @(posedge i_clk);
    endtask : tick

    task t_reset;
        rc("ctrl", acs_pkg::ADDR_CTRL, 16'h0000);
        rc("tim", acs_pkg::ADDR_TIM, 16'h0000);
        rc("ivl", acs_pkg::ADDR_IVL, 16'h0040);
        rc("offp", acs_pkg::ADDR_OFFP, 16'h0200);
        rc("offn", acs_pkg::ADDR_OFFN, 16'h0200);
        rc("clr", acs_pkg::ADDR_CLR, 16'h0000);
        rc("res", acs_pkg::ADDR_RES, 16'h0000);
        rc("unmapped", 32'h5000_190E, 16'h0000);
        `CHK("offp pin", 10'h200, o_offp)
        `CHK("offn pin", 10'h200, o_offn)
    endtask : t_reset

    task t_power;
        int k;
        wr(acs_pkg::ADDR_IVL, 16'h0001);
        wr(acs_pkg::ADDR_CTRL, 16'h0021);
        #1;
        `CHK("ldo", 1'b1, o_ldo_en)
        for (k = 0; k < 200 && o_adc_en !== 1'b1; k++) begin
            @(posedge i_clk);
            #1;
        end
        `CHK("pwr delay", 1'b1, k >= 32 && k <= 40)
        if (k == 200) give_verdict();
    endtask : t_power

    task conv(input logic [15:0] ctl, input logic [15:0] tim, input int ns,
              input int w);
        wr(acs_pkg::ADDR_CTRL, ctl);
        wr(acs_pkg::ADDR_TIM, tim);
        wr(acs_pkg::ADDR_CLR, 16'hA5A5);
        rc("flag clr", acs_pkg::ADDR_CTRL, ctl);
        `CHK("irq clr", 1'b0, o_irq)
        n_start = 0;
        wr(acs_pkg::ADDR_CTRL, ctl | 16'h0002);
        wait_go();
        rc("result", acs_pkg::ADDR_RES, {VAL, 6'h00});
        rc("done", acs_pkg::ADDR_CTRL, ctl | 16'h0010);
        `CHK("irq", ctl[5], o_irq)
        `CHK("window", w, smp_w)
        repeat (40) @(posedge i_clk);
        `CHK("samples", ns, n_start)
    endtask : conv

    task t_select;
        int k;
        wr(acs_pkg::ADDR_TIM, 16'h0000);
        for (k = 6; k < 10; k++) begin
            wr(acs_pkg::ADDR_CTRL, {3'h0, k[4:0], 8'h49});
            rc("attn", acs_pkg::ADDR_TIM, {15'h0, k == 7 || k == 8});
            `CHK("attn pin", k == 7 || k == 8, o_attn)
            `CHK("sel pin", k[4:0], o_sel)
        end
        `CHK("clk sel", 1'b1, o_clk_sel)
        `CHK("se", 1'b1, o_se)
        `CHK("offp en", 1'b1, o_offp_en)
        wr(acs_pkg::ADDR_CTRL, 16'h2049);
        repeat (3) @(posedge i_clk);
        #1;
        `CHK("offn en", 1'b1, o_offn_en)
        `CHK("offp off", 1'b0, o_offp_en)
        wr(acs_pkg::ADDR_CTRL, 16'h0021);
    endtask : t_select

    task t_repeat;
        wr(acs_pkg::ADDR_IVL, 16'h0201);
        n_start = 0;
        wr(acs_pkg::ADDR_CTRL, 16'h0027);
        repeat (300) @(posedge i_clk);
        `CHK("gap hold", 1, n_start)
        tick();
        repeat (300) @(posedge i_clk);
        `CHK("gap one tick", 1, n_start)
        tick();
        repeat (300) @(posedge i_clk);
        `CHK("gap two ticks", 2, n_start)
        wr(acs_pkg::ADDR_IVL, 16'h0001);
        tick();
        tick();
        repeat (300) @(posedge i_clk);
        `CHK("no gap", 1'b1, n_start > 5)
        wr(acs_pkg::ADDR_CTRL, 16'h0021);
        wait_go();
        n_start = 0;
        repeat (100) @(posedge i_clk);
        `CHK("stopped", 0, n_start)
        wr(acs_pkg::ADDR_CTRL, 16'h0000);
        #1;
        `CHK("ldo off", 1'b0, o_ldo_en)
        `CHK("adc off", 1'b0, o_adc_en)
    endtask : t_repeat

    initial begin
        i_rst_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_tick = 1'b0;
        i_addr = 32'h0000_0000;
        i_wdata = 16'h0000;
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_power();
        for (j = 0; j < 8; j++) begin
            conv(16'h0021, {8'h00, j[2:0], 5'h00}, 1 << j, 1);
        end
        conv(16'h0021, 16'hA100, 1, 32);
        conv(16'h4001, 16'h0000, 2, 1);
        `CHK("chop sign", 1'b1, sg[1] != sg[0])
        t_select();
        t_repeat();
        give_verdict();
    end
endmodule : testbench
